// ---- src/fspc_buf_if.sv ----
// Port bundle between controller and temporary page buffer
`timescale 1ns/1ps
interface fspc_buf_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [15:0] wr_data;
  logic clr;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output clr,
                output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input clr,
                 input rd_idx, output rd_data);
endinterface : fspc_buf_if

// ---- src/fspc_consts.svh ----
// Constants for the flash self-program controller
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
// ----------------------------------------
// Register map (word index, byte = 4 x index)
// ----------------------------------------
`define FSPC_CTL_IDX 10'h037
`define FSPC_STAT_IDX 10'h038
`define FSPC_CTL_RESET 5'h00
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define FSPC_B_IE 7
`define FSPC_B_EN 0
`define FSPC_CMD_MSB 4
// ----------------------------------------
// Command patterns in the low five bits
// ----------------------------------------
`define FSPC_P_REEN 5'h11
`define FSPC_P_LOCK 5'h09
`define FSPC_P_PWR 5'h05
`define FSPC_P_PER 5'h03
`define FSPC_P_FILL 5'h01
// ----------------------------------------
// Arming window
// ----------------------------------------
`define FSPC_WIN 3'h4
`define FSPC_LPM_MIN 3'h2
// ----------------------------------------
// Flash layout
// ----------------------------------------
`define FSPC_RWW_PAGES 7'h70
`define FSPC_BOOT_128 13'h1F80
`define FSPC_BOOT_256 13'h1F00
`define FSPC_BOOT_512 13'h1E00
`define FSPC_BOOT_1K 13'h1C00
`define FSPC_BUF_ERASED 16'hFFFF
// ----------------------------------------
// Programming time
// ----------------------------------------
`define FSPC_TPROG_MIN_NS 3700000
`define FSPC_TPROG_MAX_NS 4500000
`define FSPC_CLK_NS 100
`endif

// ---- src/fspc_page_buf.sv ----
// Temporary page buffer, 64 words of flip-flops
`timescale 1ns/1ps
`include "fspc_consts.svh"
module fspc_page_buf (
  input wire logic mclk_in,
  input wire logic resetn_in,
  fspc_buf_if.store bif
);
  import fspc_pkg::*;
  fspc_word_t mem_r [64];

  // Clear beats a same-cycle write: an aborted load keeps nothing
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 64; i++) begin
        mem_r[i] <= `FSPC_BUF_ERASED;
      end
    end else if (bif.clr) begin
      for (int i = 0; i < 64; i++) begin
        mem_r[i] <= `FSPC_BUF_ERASED;
      end
    end else if (bif.wr_en) begin
      mem_r[bif.wr_idx] <= bif.wr_data;
    end
  end

  assign bif.rd_data = mem_r[bif.rd_idx];

  a_word_store: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    bif.wr_en && !bif.clr |=> mem_r[$past(bif.wr_idx)] == $past(bif.wr_data))
    else $error("buffer word not stored");
endmodule : fspc_page_buf

// ---- src/fspc_pkg.sv ----
// Types shared by the flash self-program controller
package fspc_pkg;
  typedef enum logic [1:0] {
    FSPC_IDLE,
    FSPC_ARMED,
    FSPC_OP
  } fspc_state_t;
  typedef logic [15:0] fspc_word_t;
endpackage : fspc_pkg

// ---- src/fspc_prog_timer.sv ----
// Programming time window around the flash array's done signal
`timescale 1ns/1ps
module fspc_prog_timer #(
  parameter int MIN_CYC = 37000,
  parameter int MAX_CYC = 45000
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic array_done_in,
  output logic active_out,
  output logic done_out
);
  localparam logic [15:0] MIN_L = 16'(MIN_CYC - 1);
  localparam logic [15:0] MAX_L = 16'(MAX_CYC - 1);
  logic [15:0] cnt_r;
  logic active_r;

  // array completion, held to the legal window
  assign done_out = active_r && ((array_done_in && cnt_r >= MIN_L) || cnt_r == MAX_L);
  assign active_out = active_r;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (start_in && !active_r) begin
      active_r <= 1'b1;
      cnt_r <= 16'h0000;
    end else if (done_out) begin
      active_r <= 1'b0;
    end else if (active_r) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  a_done_early: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    done_out |-> cnt_r >= MIN_L)
    else $error("operation ended before minimum time");
  a_done_late: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    active_r && cnt_r == MAX_L |-> done_out ##1 !active_r)
    else $error("operation overran maximum time");
endmodule : fspc_prog_timer

// ---- src/fspc_top.sv ----
// Flash self-program controller with APB register access
// Behaviour
// - Boot area start chosen by boot-size fuses
// - Pages below 112 form the read-during-write area
// - Pointer bits 6:1 pick buffer word
// - Pointer bits 13:7 pick erase/write page
// - Pointer bits 15:14 ignored; bit0 selects byte
// - Control bit 5 always reads zero
// - Ready interrupt requested while enable bit clear
// - Read-during-write erase/write sets busy flag
// - Busy clears on re-enable or buffer load
// - Re-enable command clears busy when idle
// - Re-enable write aborts buffer load, discards data
// - Lock-set command programs lock bits from R0
// - Load within three cycles reads lock/fuse
// - Page-write command writes buffer to page
// - CPU stalled for no-read-during-write page
// - Page-erase command erases addressed page
// - Plain enable stores data pair into buffer
// - Enable lasts four cycles, held during operation
// - Undefined command patterns are ignored
// - Operations take 3.7 to 4.5 ms
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "fspc_consts.svh"
module fspc_top #(
  parameter int PROG_MIN_CYC = (`FSPC_TPROG_MIN_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS,
  parameter int PROG_MAX_CYC = `FSPC_TPROG_MAX_NS / `FSPC_CLK_NS
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic spm_in,
  input wire logic lpm_in,
  input wire logic [15:0] ptr_in,
  input wire logic [15:0] data_word_register_pair_in,
  input wire logic gie_in,
  input wire logic [1:0] boot_size_fuse_in,
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] fuse_byte_in,
  input wire logic flash_done_in,
  input wire logic [5:0] array_rd_idx_in,
  output logic [15:0] array_rd_data_out,
  output logic page_erase_cmd_out,
  output logic page_write_cmd_out,
  output logic [6:0] page_select_field_out,
  output logic lock_bits_set_cmd_out,
  output logic [7:0] lock_data_out,
  output logic lpm_special_out,
  output logic [7:0] lpm_data_out,
  output logic rw_area_busy_flag_out,
  output logic cpu_stall_out,
  output logic spm_irq_out,
  output logic [12:0] boot_start_out
);
  import fspc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  fspc_state_t state_r;
  logic [4:0] cmd_r;
  logic [2:0] win_r;
  logic ready_interrupt_enable_r;
  logic busy_r;
  logic load_act_r;
  logic stall_r;
  logic op_lock_r;
  logic op_write_r;
  logic [31:0] prdata_r;
  logic erase_r, write_r, lockset_r;
  logic [6:0] page_r;
  logic [7:0] lock_data_r;
  logic lpm_sp_r;
  logic [7:0] lpm_data_r;
  logic t_active, t_done;

  fspc_buf_if bif ();

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [9:0] widx;
  logic apb_acc, apb_setup, hit_ctl, hit_stat;
  logic wr_ctl, pat_ok, cmd_wr;
  logic [4:0] pat;

  assign widx = paddr_in[11:2];
  assign apb_acc = psel_in && penable_in;
  assign apb_setup = psel_in && !penable_in;
  assign hit_ctl = widx == `FSPC_CTL_IDX;
  assign hit_stat = widx == `FSPC_STAT_IDX;
  assign wr_ctl = apb_acc && pwrite_in && hit_ctl;
  assign pat = pwdata_in[`FSPC_CMD_MSB:0];
  assign pat_ok = pat == `FSPC_P_REEN || pat == `FSPC_P_LOCK ||
                  pat == `FSPC_P_PWR || pat == `FSPC_P_PER || pat == `FSPC_P_FILL;
  // no re-arming while an operation runs
  assign cmd_wr = wr_ctl && pat_ok && state_r != FSPC_OP;
  assign pready_out = 1'b1;
  assign pslverr_out = apb_acc && !(hit_ctl || hit_stat);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic is_fill, is_erase, is_write, is_lock, is_reen;
  logic spm_hit, start_pg, start_op, tgt_rww, lpm_ok;
  logic [6:0] tgt_page;

  assign is_fill = cmd_r == `FSPC_P_FILL;
  assign is_erase = cmd_r == `FSPC_P_PER;
  assign is_write = cmd_r == `FSPC_P_PWR;
  assign is_lock = cmd_r == `FSPC_P_LOCK;
  assign is_reen = cmd_r == `FSPC_P_REEN;
  // A store in the same cycle as a control write is dropped; a defined pattern re-arms
  assign spm_hit = spm_in && state_r == FSPC_ARMED && !wr_ctl;
  // page from pointer high bits, top two bits unused
  assign tgt_page = ptr_in[13:7];
  // read-during-write area is the low 112 pages
  assign tgt_rww = tgt_page < `FSPC_RWW_PAGES;
  // erase and write start on an armed store
  assign start_pg = spm_hit && (is_erase || is_write);
  // lock set is a timed operation too
  assign start_op = start_pg || (spm_hit && is_lock);
  // three-cycle read window for lock and fuse bits
  assign lpm_ok = lpm_in && state_r == FSPC_ARMED && is_lock && win_r >= `FSPC_LPM_MIN;

  // ----------------------------------------
  // Arming window and command bits
  // ----------------------------------------
  // four-cycle enable, held through the operation
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= FSPC_IDLE;
      cmd_r <= `FSPC_CTL_RESET;
      win_r <= 3'h0;
    end else if (cmd_wr) begin
      state_r <= FSPC_ARMED;
      cmd_r <= pat;
      win_r <= `FSPC_WIN;
    end else begin
      case (state_r)
        FSPC_ARMED: begin
          if (start_op) begin
            state_r <= FSPC_OP;
          end else if (spm_hit || win_r == 3'h1) begin
            state_r <= FSPC_IDLE;
            cmd_r <= `FSPC_CTL_RESET;
          end else begin
            win_r <= win_r - 3'h1;
          end
        end
        FSPC_OP: begin
          if (t_done) begin
            state_r <= FSPC_IDLE;
            cmd_r <= `FSPC_CTL_RESET;
          end
        end
        default: begin
          state_r <= FSPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_interrupt_enable_r <= 1'b0;
    end else if (wr_ctl) begin
      ready_interrupt_enable_r <= pwdata_in[`FSPC_B_IE];
    end
  end

  // ----------------------------------------
  // Busy flag and buffer load tracking
  // ----------------------------------------
  // set on erase/write into the busy area; set beats clear
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_r <= 1'b0;
    end else if (start_pg && tgt_rww) begin
      busy_r <= 1'b1;
    // re-enable or buffer load clears it
    end else if (spm_hit && (is_reen || is_fill)) begin
      busy_r <= 1'b0;
    end
  end

  logic load_abort, write_end;
  // re-enable write during a load discards the buffer
  assign load_abort = cmd_wr && pat == `FSPC_P_REEN && load_act_r;
  assign write_end = t_done && op_write_r;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_act_r <= 1'b0;
    end else if (spm_hit && is_fill) begin
      load_act_r <= 1'b1;
    end else if (load_abort || write_end) begin
      load_act_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Temporary buffer and programming timer
  // ----------------------------------------
  // plain enable stores the data pair
  assign bif.wr_en = spm_hit && is_fill;
  assign bif.wr_idx = ptr_in[6:1];
  assign bif.wr_data = data_word_register_pair_in;
  // Buffer comes back erased after a finished page write
  assign bif.clr = load_abort || write_end;
  assign bif.rd_idx = array_rd_idx_in;
  assign array_rd_data_out = bif.rd_data;

  fspc_page_buf u_buf (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .bif(bif)
  );

  fspc_prog_timer #(
    .MIN_CYC(PROG_MIN_CYC),
    .MAX_CYC(PROG_MAX_CYC)
  ) u_timer (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .start_in(start_op),
    .array_done_in(flash_done_in),
    .active_out(t_active),
    .done_out(t_done)
  );

  // ----------------------------------------
  // Operation tracking and CPU stall
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_lock_r <= 1'b0;
      op_write_r <= 1'b0;
    end else if (start_op) begin
      op_lock_r <= is_lock;
      op_write_r <= is_write;
    end else if (t_done) begin
      op_lock_r <= 1'b0;
      op_write_r <= 1'b0;
    end
  end

  // halt the CPU while its own code area is programmed
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stall_r <= 1'b0;
    end else if (start_pg && !tgt_rww) begin
      stall_r <= 1'b1;
    end else if (t_done) begin
      stall_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Flash array commands
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      erase_r <= 1'b0;
      write_r <= 1'b0;
      lockset_r <= 1'b0;
      page_r <= 7'h00;
      lock_data_r <= 8'h00;
    end else begin
      erase_r <= start_pg && is_erase;
      write_r <= start_pg && is_write;
      lockset_r <= spm_hit && is_lock;
      if (start_pg) begin
        page_r <= tgt_page;
      end
      // only R0 matters; R1 and pointer ignored
      if (spm_hit && is_lock) begin
        lock_data_r <= data_word_register_pair_in[7:0];
      end
    end
  end

  // pointer bit 0 picks fuse or lock byte
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lpm_sp_r <= 1'b0;
      lpm_data_r <= 8'h00;
    end else begin
      lpm_sp_r <= lpm_ok;
      if (lpm_ok) begin
        lpm_data_r <= ptr_in[0] ? fuse_byte_in : lock_bits_in;
      end
    end
  end

  // ----------------------------------------
  // Boot area and register read-back
  // ----------------------------------------
  // boot start from fuse code; application below it
  always_comb begin
    case (boot_size_fuse_in)
      2'h3: boot_start_out = `FSPC_BOOT_128;
      2'h2: boot_start_out = `FSPC_BOOT_256;
      2'h1: boot_start_out = `FSPC_BOOT_512;
      default: boot_start_out = `FSPC_BOOT_1K;
    endcase
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup && hit_ctl) begin
      prdata_r <= {24'h000000, ready_interrupt_enable_r, busy_r, 1'b0, cmd_r};
    end else if (apb_setup && hit_stat) begin
      prdata_r <= {27'h0000000, boot_size_fuse_in, load_act_r, stall_r, t_active};
    end else if (apb_setup) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  assign prdata_out = prdata_r;
  assign page_erase_cmd_out = erase_r;
  assign page_write_cmd_out = write_r;
  assign page_select_field_out = page_r;
  assign lock_bits_set_cmd_out = lockset_r;
  assign lock_data_out = lock_data_r;
  assign lpm_special_out = lpm_sp_r;
  assign lpm_data_out = lpm_data_r;
  assign rw_area_busy_flag_out = busy_r;
  assign cpu_stall_out = stall_r;
  // ready request while the enable bit reads zero
  assign spm_irq_out = ready_interrupt_enable_r && gie_in && !cmd_r[`FSPC_B_EN];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_irq_level: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    ready_interrupt_enable_r && gie_in && state_r == FSPC_IDLE |-> spm_irq_out)
    else $error("ready interrupt missing while idle");
  a_res_zero: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    apb_acc && !pwrite_in && hit_ctl |-> !prdata_out[5])
    else $error("reserved bit read as one");
  a_busy_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    start_pg && tgt_rww |=> busy_r && rw_area_busy_flag_out)
    else $error("busy flag not set");
  a_busy_fill: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    spm_hit && is_fill |=> !busy_r)
    else $error("buffer load left busy flag set");
  a_win_timeout: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    cmd_wr ##1 (!spm_in && !wr_ctl)[*4] |=> cmd_r == `FSPC_CTL_RESET)
    else $error("enable window did not expire");
  a_en_held: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    state_r == FSPC_OP && !t_done |=> cmd_r[`FSPC_B_EN])
    else $error("enable dropped during operation");
  // Window expiry and completion still move state on an ignored write
  a_bad_cmd: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_ctl && !pat_ok && !t_done && !(state_r == FSPC_ARMED && win_r == 3'h1)
      |=> $stable(cmd_r) && $stable(state_r))
    else $error("undefined pattern changed state");
  a_page_sel: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    spm_hit && is_erase |=> page_erase_cmd_out && page_select_field_out == $past(ptr_in[13:7]))
    else $error("erase page not taken from pointer");
  a_stall_no_read_during_write_area: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    start_pg && !tgt_rww |=> cpu_stall_out throughout (state_r == FSPC_OP)[*2])
    else $error("cpu not stalled for protected page");
  a_lpm_window: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    cmd_wr && pat == `FSPC_P_LOCK ##1 (!wr_ctl)[*3] ##1 lpm_in && !wr_ctl
      |=> !lpm_special_out)
    else $error("lock read accepted after window");
endmodule : fspc_top

// ---- verif/fspc_flash_model.sv ----
// Flash array stand-in that answers each operation with a done pulse
`timescale 1ns/1ps
module fspc_flash_model (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [7:0] delay_in,
  output logic done_out
);
  logic [7:0] cnt_r;
  logic run_r;
  // ----------------------------------------
  // Completion timing
  // ----------------------------------------
  // delayed done pulse
  // A long delay lets the controller's own maximum time end the operation
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        run_r <= 1'b1;
        cnt_r <= delay_in;
      end else if (run_r && cnt_r == 8'h00) begin
        run_r <= 1'b0;
        done_out <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : fspc_flash_model

// ---- verif/test_flash_self_program_control.sv ----
// Self-checking bench for the flash self-program controller
`timescale 1ns/1ps
module test_flash_self_program_control;
  import fspc_pkg::*;
  localparam logic [11:0] CTL = 12'h0DC;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, spm = 1'b0, lpm = 1'b0, gie = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [15:0] ptr = 16'h0, dat = 16'h0, bufq;
  logic [1:0] fuse = 2'h0;
  logic [5:0] ridx = 6'h00;
  logic [7:0] dly = 8'h06, lkq, lpq;
  logic [31:0] prdata;
  logic pready, pslverr, ers, pwt, lks, lps, busy, stall, irq, done, e;
  logic [6:0] page;
  logic [7:0] lkd, lpd;
  logic [12:0] boot;
  int failures = 0, num_checks = 0, n_ers = 0, n_wr = 0, n_lk = 0, n_lp = 0;
  logic [12:0] bt [4] = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};

  always #50 mclk_in = ~mclk_in;

  fspc_top #(.PROG_MIN_CYC(8), .PROG_MAX_CYC(12)) u_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .spm_in(spm), .lpm_in(lpm),
    .ptr_in(ptr), .data_word_register_pair_in(dat), .gie_in(gie),
    .boot_size_fuse_in(fuse), .lock_bits_in(8'hC3), .fuse_byte_in(8'h5E),
    .flash_done_in(done), .array_rd_idx_in(ridx), .array_rd_data_out(bufq),
    .page_erase_cmd_out(ers), .page_write_cmd_out(pwt), .page_select_field_out(page),
    .lock_bits_set_cmd_out(lks), .lock_data_out(lkd), .lpm_special_out(lps),
    .lpm_data_out(lpd), .rw_area_busy_flag_out(busy), .cpu_stall_out(stall),
    .spm_irq_out(irq), .boot_start_out(boot));

  fspc_flash_model u_flash (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .start_in(ers | pwt | lks), .delay_in(dly), .done_out(done));

  // Pulses last one cycle, so they are caught here rather than polled
  always @(posedge mclk_in) begin
    if (ers === 1'b1) n_ers++;
    if (pwt === 1'b1) n_wr++;
    if (lks === 1'b1) begin
      n_lk++;
      lkq = lkd;
    end
    if (lps === 1'b1) begin
      n_lp++;
      lpq = lpd;
    end
  end

  task automatic print_verdict;
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk_in);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic spm_op(input logic [15:0] z, input logic [15:0] d);
    ptr <= z;
    dat <= d;
    spm <= 1'b1;
    @(posedge mclk_in);
    spm <= 1'b0;
  endtask : spm_op

  task automatic wait_idle;
    int i;
    for (i = 0; i < 40; i++) begin
      apb(1'b0, CTL, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (i == 40) begin
      failures++;
      print_verdict();
    end
  endtask : wait_idle

  task automatic look(input logic [5:0] idx, input logic [15:0] ex);
    ridx <= idx;
    @(posedge mclk_in);
    chk("buffer_word", {16'h0, ex}, {16'h0, bufq});
  endtask : look

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    apb(1'b0, CTL, 32'h0);
    chk("ctrl_reset", 32'h0, q);
    for (int f = 0; f < 4; f++) begin
      fuse <= f[1:0];
      @(posedge mclk_in);
      @(posedge mclk_in);
      chk("boot_start", {19'h0, bt[f]}, {19'h0, boot});
    end
    gie <= 1'b1;
    apb(1'b1, CTL, 32'h80);
    // Interrupt-enable bit 7 lands at the access edge; look once it has settled
    @(posedge mclk_in);
    chk("irq_idle", 32'h1, {31'h0, irq});
    apb(1'b1, CTL, 32'h27);
    apb(1'b0, CTL, 32'h0);
    chk("ctrl_bad_pattern", 32'h0, q);
    apb(1'b1, CTL, 32'h01);
    spm_op(16'hC00B, 16'h1234);
    look(6'd5, 16'h1234);
    apb(1'b0, CTL, 32'h0);
    chk("enable_after_store", 32'h0, q);
    // Store on the last cycle of the window, then one cycle too late
    for (int k = 3; k < 5; k++) begin
      apb(1'b1, CTL, 32'h01);
      repeat (k) @(posedge mclk_in);
      spm_op({9'h0, k[5:0], 1'b0}, 16'h5555);
      look(k[5:0], k == 3 ? 16'h5555 : 16'hFFFF);
    end
    apb(1'b1, CTL, 32'h01);
    spm_op(16'h0012, 16'hBEEF);
    apb(1'b1, CTL, 32'h11);
    look(6'd9, 16'hFFFF);
    repeat (6) @(posedge mclk_in);
    apb(1'b1, CTL, 32'h83);
    spm_op(16'h0280, 16'h7777);
    repeat (3) @(posedge mclk_in);
    chk("erase_count", 32'h1, n_ers);
    chk("erase_page", 32'h5, {25'h0, page});
    chk("busy_rww", 32'h1, {31'h0, busy});
    chk("irq_during_op", 32'h0, {31'h0, irq});
    apb(1'b1, CTL, 32'h91);
    spm_op(16'h0, 16'h0);
    wait_idle();
    chk("busy_after_early_reenable", 32'h1, {31'h0, busy});
    chk("irq_after_op", 32'h1, {31'h0, irq});
    apb(1'b1, CTL, 32'h91);
    spm_op(16'h0, 16'h0);
    repeat (2) @(posedge mclk_in);
    chk("busy_reenable", 32'h0, {31'h0, busy});
    // Slow array: the controller's maximum time must end the write
    dly <= 8'h1E;
    apb(1'b1, CTL, 32'h05);
    spm_op(16'h3C00, 16'h0);
    repeat (3) @(posedge mclk_in);
    chk("write_count", 32'h1, n_wr);
    chk("stall_no_read_during_write_area", 32'h1, {31'h0, stall});
    chk("busy_no_read_during_write_area", 32'h0, {31'h0, busy});
    apb(1'b0, 12'h0E0, 32'h0);
    chk("status_op", 32'h1B, q);
    wait_idle();
    repeat (2) @(posedge mclk_in);
    chk("stall_end", 32'h0, {31'h0, stall});
    dly <= 8'h06;
    apb(1'b1, CTL, 32'h05);
    spm_op(16'h0080, 16'h0);
    wait_idle();
    apb(1'b1, CTL, 32'h01);
    spm_op(16'h0004, 16'h1111);
    repeat (2) @(posedge mclk_in);
    chk("busy_fill_clear", 32'h0, {31'h0, busy});
    apb(1'b1, CTL, 32'h09);
    spm_op(16'hFFFF, 16'h33A5);
    wait_idle();
    chk("lock_count", 32'h1, n_lk);
    chk("lock_data", 32'hA5, {24'h0, lkq});
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, CTL, 32'h09);
      ptr <= {15'h0, b[0]};
      lpm <= 1'b1;
      @(posedge mclk_in);
      lpm <= 1'b0;
      repeat (6) @(posedge mclk_in);
      chk("lpm_data", b ? 32'h5E : 32'hC3, {24'h0, lpq});
    end
    // Load on the fourth cycle is past the read window
    apb(1'b1, CTL, 32'h09);
    repeat (3) @(posedge mclk_in);
    lpm <= 1'b1;
    @(posedge mclk_in);
    lpm <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk("lpm_late", 32'h2, n_lp);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    print_verdict();
  end
endmodule : test_flash_self_program_control
